// [hw/port_pin_pkg.sv]
package port_pin_pkg;

    // register word indexes; byte address is four times the index
    localparam int unsigned IDX_W = 8;
    localparam int unsigned ADDR_LSB = 2;
    localparam logic [IDX_W-1:0] IDX_SMALL_POL = 8'h2d;
    localparam logic [IDX_W-1:0] IDX_SMALL_IEN = 8'h2e;
    localparam logic [IDX_W-1:0] IDX_SMALL_FLAGS = 8'h2f;
    localparam logic [IDX_W-1:0] IDX_AD_DATA = 8'h30;
    localparam logic [IDX_W-1:0] IDX_AD_PIN_INPUT = 8'h31;
    localparam logic [IDX_W-1:0] IDX_AD_DIRECTION = 8'h32;
    localparam logic [IDX_W-1:0] IDX_AD_DRIVE = 8'h33;
    localparam logic [IDX_W-1:0] IDX_AD_PULL_EN = 8'h34;
    localparam logic [IDX_W-1:0] IDX_AD_PULL_SEL = 8'h35;

    // register width and placement of the small port bits
    localparam int unsigned REG_W = 8;
    localparam int unsigned SMALL_PINS = 2;
    localparam int unsigned SMALL_LSB = 6;

    // reset values
    localparam logic [REG_W-1:0] RST_AD_REG = 8'h00;
    localparam logic [SMALL_PINS-1:0] RST_SMALL_REG = 2'h0;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_SMALL_POL = 4'h1,
        SEL_SMALL_IEN = 4'h3,
        SEL_SMALL_FLAGS = 4'h2,
        SEL_AD_DATA = 4'h6,
        SEL_AD_PIN_INPUT = 4'h7,
        SEL_AD_DIRECTION = 4'h5,
        SEL_AD_DRIVE = 4'h4,
        SEL_AD_PULL_EN = 4'hc,
        SEL_AD_PULL_SEL = 4'hd
    } reg_sel_e;

endpackage : port_pin_pkg

// [hw/port_pin_io.sv]
`timescale 1ns/100ps

// Notes on behaviour
// - edge sets small port flag bits 7:6
// - polarity bit picks rising or falling edge
// - flag clears on written one only
// - irq when flag and enable both set
// - disabled enable masks irq, flag still sets
// - data read: latch if output, pin if input
// - readback choice depends on direction only
// - pin input register read-only, live pins
// - direction bit zero input, one output
// - readback settles within two bus cycles
// - reduced drive honoured for outputs only
// - pull only for enabled inputs, off at reset
// - analog channel enabled suppresses pull device
// - select zero pull-up, one pull-down
// - registers writable anytime, effect when usable
// - latch drives pin only as gpio output
// - peripheral may drive or receive each pin
// - peripheral control overrides direction bit
module port_pin_io
    import port_pin_pkg::*;
#(
    parameter int unsigned AD_PINS = 8,
    parameter int unsigned AXI_ADDR_W = 12
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [AXI_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [AXI_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // small port pins and interrupt
    input wire logic [SMALL_PINS-1:0] small_pin_in,
    output logic small_port_irq,
    // analog-shared port pins
    input wire logic [AD_PINS-1:0] ad_pin_in,
    output logic [AD_PINS-1:0] ad_pin_out,
    output logic [AD_PINS-1:0] ad_pin_oe,
    output logic [AD_PINS-1:0] ad_reduced_drive,
    output logic [AD_PINS-1:0] ad_pull_en,
    output logic [AD_PINS-1:0] ad_pull_down,
    // analog converter channel enables
    input wire logic [AD_PINS-1:0] analog_converter_enable,
    // peripheral takeover
    input wire logic [AD_PINS-1:0] periph_ctrl,
    input wire logic [AD_PINS-1:0] periph_oe,
    input wire logic [AD_PINS-1:0] periph_out,
    output logic [AD_PINS-1:0] periph_in
);

    if (AD_PINS < 1 || AD_PINS > REG_W) begin : g_bad_pins
        $error("AD_PINS must lie between 1 and 8");
    end
    if (AXI_ADDR_W < ADDR_LSB + IDX_W) begin : g_bad_addr
        $error("AXI_ADDR_W too narrow for the register map");
    end

    typedef struct packed {
        logic aw_got;
        logic [IDX_W-1:0] aw_idx;
        logic w_got;
        logic [REG_W-1:0] w_byte;
        logic w_lane;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [REG_W-1:0] rdata;
        logic [1:0] rresp;
        logic [AD_PINS-1:0] ad_latch;
        logic [AD_PINS-1:0] ad_dir;
        logic [AD_PINS-1:0] ad_drive;
        logic [AD_PINS-1:0] ad_pull_en;
        logic [AD_PINS-1:0] ad_pull_sel;
        logic [SMALL_PINS-1:0] small_pol;
        logic [SMALL_PINS-1:0] small_ien;
        logic [SMALL_PINS-1:0] small_flags;
        logic [AD_PINS-1:0] ad_sync1;
        logic [AD_PINS-1:0] ad_sync2;
        logic [SMALL_PINS-1:0] small_sync1;
        logic [SMALL_PINS-1:0] small_sync2;
        logic [SMALL_PINS-1:0] small_prev;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    function automatic reg_sel_e decode(input logic [IDX_W-1:0] idx);
        case (idx)
            IDX_SMALL_POL: decode = SEL_SMALL_POL;
            IDX_SMALL_IEN: decode = SEL_SMALL_IEN;
            IDX_SMALL_FLAGS: decode = SEL_SMALL_FLAGS;
            IDX_AD_DATA: decode = SEL_AD_DATA;
            IDX_AD_PIN_INPUT: decode = SEL_AD_PIN_INPUT;
            IDX_AD_DIRECTION: decode = SEL_AD_DIRECTION;
            IDX_AD_DRIVE: decode = SEL_AD_DRIVE;
            IDX_AD_PULL_EN: decode = SEL_AD_PULL_EN;
            IDX_AD_PULL_SEL: decode = SEL_AD_PULL_SEL;
            default: decode = SEL_NONE;
        endcase
    endfunction : decode

    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic have_aw;
    logic have_w;
    logic do_write;
    logic [IDX_W-1:0] wr_idx;
    logic [REG_W-1:0] wr_byte;
    logic wr_lane;
    reg_sel_e wr_sel;
    reg_sel_e rd_sel;
    logic [SMALL_PINS-1:0] small_edge;
    logic [SMALL_PINS-1:0] flag_clear;
    logic [AD_PINS-1:0] ad_readback;
    logic [AD_PINS-1:0] gpio_out;

    assign awready = !st_ff.aw_got && !st_ff.bvalid;
    assign wready = !st_ff.w_got && !st_ff.bvalid;
    assign arready = !st_ff.rvalid;
    assign bvalid = st_ff.bvalid;
    assign bresp = st_ff.bresp;
    assign rvalid = st_ff.rvalid;
    assign rresp = st_ff.rresp;
    assign rdata = {24'h000000, st_ff.rdata};

    assign aw_fire = awvalid && awready;
    assign w_fire = wvalid && wready;
    assign ar_fire = arvalid && arready;
    assign have_aw = st_ff.aw_got || aw_fire;
    assign have_w = st_ff.w_got || w_fire;
    assign do_write = have_aw && have_w;
    assign wr_idx = st_ff.aw_got ? st_ff.aw_idx : awaddr[ADDR_LSB +: IDX_W];
    assign wr_byte = st_ff.w_got ? st_ff.w_byte : wdata[REG_W-1:0];
    assign wr_lane = st_ff.w_got ? st_ff.w_lane : wstrb[0];
    assign wr_sel = decode(wr_idx);
    assign rd_sel = decode(araddr[ADDR_LSB +: IDX_W]);

    // edge detection on synchronised small port pins
    assign small_edge = (st_ff.small_pol & st_ff.small_sync2 & ~st_ff.small_prev)
        | (~st_ff.small_pol & ~st_ff.small_sync2 & st_ff.small_prev);
    assign flag_clear = (do_write && wr_lane && wr_sel == SEL_SMALL_FLAGS)
        ? wr_byte[SMALL_LSB +: SMALL_PINS] : RST_SMALL_REG;

    // direction alone picks latch or pin for readback
    assign ad_readback = (st_ff.ad_dir & st_ff.ad_latch)
        | (~st_ff.ad_dir & st_ff.ad_sync2);

    assign small_port_irq = |(st_ff.small_flags & st_ff.small_ien);

    // pin drive and pad controls
    assign gpio_out = st_ff.ad_dir & ~periph_ctrl;
    assign ad_pin_oe = (periph_ctrl & periph_oe) | gpio_out;
    assign ad_pin_out = (periph_ctrl & periph_out) | (~periph_ctrl & st_ff.ad_latch);
    assign ad_reduced_drive = st_ff.ad_drive & ad_pin_oe;
    assign ad_pull_en = st_ff.ad_pull_en & ~ad_pin_oe & ~analog_converter_enable;
    assign ad_pull_down = ad_pull_en & st_ff.ad_pull_sel;
    assign periph_in = st_ff.ad_sync2;

    always_comb begin
        nxt_st = st_ff;
        // two-flop synchronisers
        nxt_st.ad_sync1 = ad_pin_in;
        nxt_st.ad_sync2 = st_ff.ad_sync1;
        nxt_st.small_sync1 = small_pin_in;
        nxt_st.small_sync2 = st_ff.small_sync1;
        nxt_st.small_prev = st_ff.small_sync2;
        // set wins over a clear in the same cycle
        nxt_st.small_flags = (st_ff.small_flags & ~flag_clear) | small_edge;

        if (aw_fire) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_idx = awaddr[ADDR_LSB +: IDX_W];
        end
        if (w_fire) begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_byte = wdata[REG_W-1:0];
            nxt_st.w_lane = wstrb[0];
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wr_lane) begin
                case (wr_sel)
                    SEL_SMALL_POL: nxt_st.small_pol = wr_byte[SMALL_LSB +: SMALL_PINS];
                    SEL_SMALL_IEN: nxt_st.small_ien = wr_byte[SMALL_LSB +: SMALL_PINS];
                    SEL_AD_DATA: nxt_st.ad_latch = wr_byte[AD_PINS-1:0];
                    SEL_AD_DIRECTION: nxt_st.ad_dir = wr_byte[AD_PINS-1:0];
                    SEL_AD_DRIVE: nxt_st.ad_drive = wr_byte[AD_PINS-1:0];
                    SEL_AD_PULL_EN: nxt_st.ad_pull_en = wr_byte[AD_PINS-1:0];
                    SEL_AD_PULL_SEL: nxt_st.ad_pull_sel = wr_byte[AD_PINS-1:0];
                    default: ; // flags handled above, pin input ignores writes
                endcase
            end
        end

        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (ar_fire) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = RESP_OKAY;
            nxt_st.rdata = RST_AD_REG;
            case (rd_sel)
                SEL_SMALL_POL: nxt_st.rdata[SMALL_LSB +: SMALL_PINS] = st_ff.small_pol;
                SEL_SMALL_IEN: nxt_st.rdata[SMALL_LSB +: SMALL_PINS] = st_ff.small_ien;
                SEL_SMALL_FLAGS: nxt_st.rdata[SMALL_LSB +: SMALL_PINS] = st_ff.small_flags;
                SEL_AD_DATA: nxt_st.rdata[AD_PINS-1:0] = ad_readback;
                SEL_AD_PIN_INPUT: nxt_st.rdata[AD_PINS-1:0] = st_ff.ad_sync2;
                SEL_AD_DIRECTION: nxt_st.rdata[AD_PINS-1:0] = st_ff.ad_dir;
                SEL_AD_DRIVE: nxt_st.rdata[AD_PINS-1:0] = st_ff.ad_drive;
                SEL_AD_PULL_EN: nxt_st.rdata[AD_PINS-1:0] = st_ff.ad_pull_en;
                SEL_AD_PULL_SEL: nxt_st.rdata[AD_PINS-1:0] = st_ff.ad_pull_sel;
                default: nxt_st.rresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_ff <= '0; // all pins inputs, no pull, no drive, flags clear
        end else begin
            st_ff <= nxt_st;
        end
    end

    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    logic [IDX_W-1:0] rd_idx;
    assign rd_idx = araddr[ADDR_LSB +: IDX_W];

    edge_sets_flag_a:
    assert property ((small_edge != 2'h0) |=> ((st_ff.small_flags & $past(small_edge))
        == $past(small_edge)))
        else $error("active edge did not set its flag");

    one_clears_flag_a:
    assert property (((flag_clear & ~small_edge) != 2'h0)
        |=> ((st_ff.small_flags & $past(flag_clear) & ~$past(small_edge)) == 2'h0))
        else $error("written one did not clear the flag");

    flag_holds_a:
    assert property (1'b1 |=> (($past(st_ff.small_flags) & ~$past(flag_clear)
        & ~st_ff.small_flags) == 2'h0))
        else $error("flag dropped without a written one");

    irq_gate_a:
    assert property (small_port_irq == ((st_ff.small_flags[0] && st_ff.small_ien[0])
        || (st_ff.small_flags[1] && st_ff.small_ien[1])))
        else $error("interrupt request does not follow flags and enables");

    data_readback_a:
    assert property ((ar_fire && rd_idx == IDX_AD_DATA)
        |=> (rdata[AD_PINS-1:0] == (($past(st_ff.ad_dir) & $past(st_ff.ad_latch))
        | (~$past(st_ff.ad_dir) & $past(ad_pin_in, 3)))))
        else $error("data register readback mismatch");

    pin_input_read_a:
    assert property ((ar_fire && rd_idx == IDX_AD_PIN_INPUT)
        |=> (rdata[AD_PINS-1:0] == $past(ad_pin_in, 3) && rresp == RESP_OKAY))
        else $error("pin input register not returning pins");

    sync_latency_a:
    assert property (st_ff.ad_sync2 == $past(ad_pin_in, 2))
        else $error("pin synchroniser latency is not two cycles");

    pin_drive_a:
    assert property (((~periph_ctrl & st_ff.ad_dir) != ((~periph_ctrl) & ad_pin_oe)) == 1'b0)
        else $error("gpio drive does not follow direction");

    pull_gate_a:
    assert property ((ad_pull_en & (ad_pin_oe | analog_converter_enable | ~st_ff.ad_pull_en))
        == '0 && (ad_pull_down & ~st_ff.ad_pull_sel) == '0)
        else $error("pull device enabled where it must not be");

    reduced_drive_a:
    assert property ((ad_reduced_drive & ~ad_pin_oe) == '0)
        else $error("reduced drive on an input pin");

    write_response_a:
    assert property (do_write |=> bvalid [*1] ##0 (bresp == ((($past(wr_sel) == SEL_NONE))
        ? RESP_SLVERR : RESP_OKAY)))
        else $error("write response missing or wrong");

    // flag and interrupt behaviour
    flag_needs_edge_a:
    assert property (1'b1 |=> ((st_ff.small_flags & ~$past(st_ff.small_flags)
        & ~$past(small_edge)) == 2'h0))
        else $error("flag set without an active edge");

    edge_polarity_a:
    assert property ((small_edge & ((st_ff.small_sync2 ^ st_ff.small_pol)
        | ~(st_ff.small_sync2 ^ st_ff.small_prev))) == 2'h0)
        else $error("edge seen against its polarity select");

    irq_on_flag_a:
    assert property (((st_ff.small_flags & st_ff.small_ien) != 2'h0) |-> small_port_irq)
        else $error("enabled flag raised no interrupt request");

    irq_masked_a:
    assert property (((st_ff.small_flags & st_ff.small_ien) == 2'h0) |-> !small_port_irq)
        else $error("masked flag raised an interrupt request");

    // register access
    read_answer_a:
    assert property (ar_fire |=> (rvalid && rdata[31:REG_W] == '0))
        else $error("read not answered in the next cycle");

    input_write_ignored_a:
    assert property ((do_write && wr_sel == SEL_AD_PIN_INPUT)
        |=> ($stable(st_ff.ad_latch) && $stable(st_ff.ad_dir) && $stable(st_ff.ad_pull_en)))
        else $error("write to pin input register changed state");

    dir_write_a:
    assert property ((do_write && wr_lane && wr_sel == SEL_AD_DIRECTION)
        |=> (st_ff.ad_dir == AD_PINS'($past(wr_byte))))
        else $error("direction write did not land");

    pull_en_write_a:
    assert property ((do_write && wr_lane && wr_sel == SEL_AD_PULL_EN)
        |=> (st_ff.ad_pull_en == AD_PINS'($past(wr_byte))))
        else $error("pull enable write did not land");

    // pad controls and peripheral takeover
    no_pull_a:
    assert property ((st_ff.ad_pull_en == '0) |-> (ad_pull_en == '0))
        else $error("pull device on with its enable clear");

    gpio_out_a:
    assert property ((~periph_ctrl & ad_pin_oe & (ad_pin_out ^ st_ff.ad_latch)) == '0)
        else $error("gpio output does not drive the latch");

    periph_out_a:
    assert property ((periph_ctrl & ((ad_pin_out ^ periph_out) | (ad_pin_oe ^ periph_oe)))
        == '0)
        else $error("peripheral does not own its pin");

    periph_in_a:
    assert property (periph_in == $past(ad_pin_in, 2))
        else $error("peripheral input not the synchronised pin");

endmodule : port_pin_io

// [verification/pin_pad_model.sv]
`timescale 1ns/100ps

// pad ring model: resolves each analog-port pin from the device drive,
// an outside driver, an injected short and the pull devices
module pin_pad_model #(
    parameter int unsigned PINS = 8
) (
    // clock
    input wire logic clock,
    // device side of the pads
    input wire logic [PINS-1:0] oe,
    input wire logic [PINS-1:0] out,
    input wire logic [PINS-1:0] pull_en,
    input wire logic [PINS-1:0] pull_down,
    // outside world
    input wire logic [PINS-1:0] ext_en,
    input wire logic [PINS-1:0] ext_val,
    input wire logic [PINS-1:0] short_en,
    output logic [PINS-1:0] pin
);
    logic [PINS-1:0] float_ff = '0;

    // an undriven, unpulled pin wanders every cycle
    always_ff @(posedge clock) begin
        float_ff <= ~float_ff;
    end

    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (short_en[i]) begin
                pin[i] = ext_val[i];
            end else if (oe[i]) begin
                pin[i] = out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (pull_en[i]) begin
                pin[i] = ~pull_down[i];
            end else begin
                pin[i] = float_ff[i];
            end
        end
    end
endmodule : pin_pad_model

// [verification/tb_port_pin_io_with_edge_flags.sv]
`timescale 1ns/100ps

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end

module tb_port_pin_io_with_edge_flags
    import port_pin_pkg::*;
;
    logic clock = 0, rst = 1;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, small_port_irq;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0] bresp, rresp, resp;
    logic [1:0] small_pin_in = 2'h2;
    logic [7:0] ad_pin_in, ad_pin_out, ad_pin_oe, ad_reduced_drive, ad_pull_en;
    logic [7:0] ad_pull_down, periph_in, rd;
    logic [7:0] analog_converter_enable = '0, periph_ctrl = '0, periph_oe = '0;
    logic [7:0] periph_out = '0, ext_en = 8'hff, ext_val = '0, short_en = '0;
    int n_errors = 0, total_checks = 0, cycles = 0;

    always #5 clock = ~clock;

    port_pin_io u_dut (.clock(clock), .rst(rst), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .small_pin_in(small_pin_in),
        .small_port_irq(small_port_irq), .ad_pin_in(ad_pin_in), .ad_pin_out(ad_pin_out),
        .ad_pin_oe(ad_pin_oe), .ad_reduced_drive(ad_reduced_drive),
        .ad_pull_en(ad_pull_en), .ad_pull_down(ad_pull_down),
        .analog_converter_enable(analog_converter_enable), .periph_ctrl(periph_ctrl),
        .periph_oe(periph_oe), .periph_out(periph_out), .periph_in(periph_in));

    pin_pad_model u_pads (.clock(clock), .oe(ad_pin_oe), .out(ad_pin_out),
        .pull_en(ad_pull_en), .pull_down(ad_pull_down), .ext_en(ext_en),
        .ext_val(ext_val), .short_en(short_en), .pin(ad_pin_in));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cycles++;
        if (cycles > 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!bvalid);
        resp = bresp;
        bready <= 0;
    endtask : wr

    task automatic rdr(input logic [7:0] idx);
        @(posedge clock);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 0;
        end while (!rvalid);
        rd = rdata[7:0];
        resp = rresp;
        rready <= 0;
    endtask : rdr

    initial begin
        repeat (8) @(posedge clock);
        rst <= 0;
        repeat (3) @(posedge clock);
        `CHK(ad_pull_en, 8'h00)
        rdr(IDX_AD_DIRECTION); `CHK(rd, RST_AD_REG)
        $display("test reset done");
        ext_val <= 8'h3c;
        wr(IDX_AD_DATA, 8'ha5);
        wr(IDX_AD_DIRECTION, 8'h0f);
        repeat (4) @(posedge clock);
        `CHK(ad_pin_oe, 8'h0f)
        rdr(IDX_AD_DATA); `CHK(rd, 8'h35)
        short_en <= 8'h01;
        ext_val <= 8'h3c;
        repeat (4) @(posedge clock);
        rdr(IDX_AD_DATA); `CHK(rd, 8'h35)
        rdr(IDX_AD_PIN_INPUT); `CHK(rd, 8'h34)
        wr(IDX_AD_PIN_INPUT, 8'hff); `CHK(resp, RESP_OKAY)
        rdr(IDX_AD_PIN_INPUT); `CHK(rd, 8'h34)
        short_en <= 8'h00;
        $display("test direction readback done");
        analog_converter_enable <= 8'h10;
        wr(IDX_AD_DRIVE, 8'hff);
        wr(IDX_AD_PULL_EN, 8'hff);
        wr(IDX_AD_PULL_SEL, 8'haa);
        @(posedge clock);
        `CHK(ad_reduced_drive, 8'h0f)
        `CHK(ad_pull_en, 8'he0)
        `CHK(ad_pull_down, 8'ha0)
        rdr(IDX_AD_PULL_EN); `CHK(rd, 8'hff)
        $display("test drive and pull done");
        periph_ctrl <= 8'h01;
        periph_oe <= 8'h01;
        @(posedge clock);
        @(posedge clock);
        `CHK(ad_pin_out[0], 1'b0)
        periph_oe <= 8'h00;
        ext_val <= 8'h01;
        repeat (4) @(posedge clock);
        `CHK(ad_pin_oe[0], 1'b0)
        `CHK(periph_in[0], 1'b1)
        periph_ctrl <= 8'h00;
        $display("test peripheral takeover done");
        wr(IDX_SMALL_POL, 8'h40);
        small_pin_in <= 2'h1;
        repeat (6) @(posedge clock);
        rdr(IDX_SMALL_FLAGS); `CHK(rd, 8'hc0)
        `CHK(small_port_irq, 1'b0)
        wr(IDX_SMALL_IEN, 8'h40);
        @(posedge clock);
        `CHK(small_port_irq, 1'b1)
        wr(IDX_SMALL_FLAGS, 8'h00);
        rdr(IDX_SMALL_FLAGS); `CHK(rd, 8'hc0)
        wr(IDX_SMALL_FLAGS, 8'h40);
        rdr(IDX_SMALL_FLAGS); `CHK(rd, 8'h80)
        `CHK(small_port_irq, 1'b0)
        small_pin_in <= 2'h0;
        repeat (6) @(posedge clock);
        rdr(IDX_SMALL_FLAGS); `CHK(rd, 8'h80)
        $display("test edge flags done");
        wr(8'h40, 8'h5a); `CHK(resp, RESP_SLVERR)
        rdr(8'h40); `CHK(resp, RESP_SLVERR)
        `CHK(rd, 8'h00)
        $display("test unmapped done");
        end_sim();
    end
endmodule : tb_port_pin_io_with_edge_flags
